// [hdl/lcisg_regs.svh]
`ifndef LCISG_REGS_SVH
`define LCISG_REGS_SVH

// register offsets on the plain register port
`define LCISG_ADDR_SEL0 5'h00
`define LCISG_ADDR_GLS0 5'h04
`define LCISG_ADDR_POL 5'h08
`define LCISG_ADDR_MUXST 5'h09
`define LCISG_ADDR_GATEST 5'h0A
`define LCISG_ADDR_BADSEL 5'h0B
`define LCISG_ADDR_POOL0 5'h10
`define LCISG_POOL_REGS 7

// reset values of the configuration registers
`define LCISG_RST_SEL 6'h00
`define LCISG_RST_GLS 8'h00
`define LCISG_RST_POL 4'h0

// field positions inside a gate select register
`define LCISG_GLS_TRUE_OFS 0
`define LCISG_GLS_INV_OFS 1

// selection codes, first code of each source group
`define LCISG_CODE_PIN0 6'h00
`define LCISG_CODE_CELL1 6'h04
`define LCISG_CODE_CMP1 6'h08
`define LCISG_CODE_COMP_OUTPUT_GEN1_A 6'h10
`define LCISG_CODE_CCP 6'h18
`define LCISG_CODE_PWM 6'h1C
`define LCISG_CODE_SER_CLK 6'h24
`define LCISG_CODE_SER_DAT 6'h25
`define LCISG_CODE_ZCD 6'h26
`define LCISG_CODE_UART_TX 6'h27
`define LCISG_CODE_UART_RX 6'h28
`define LCISG_CODE_TMR_OVF 6'h29
`define LCISG_CODE_TMR_PST 6'h2D
`define LCISG_CODE_IOC 6'h31
`define LCISG_CODE_RC_CLK 6'h32
`define LCISG_CODE_SLOW_OSC 6'h33
`define LCISG_CODE_FAST_OSC 6'h34
`define LCISG_CODE_SYS_CLK 6'h35
`define LCISG_CODE_MOD_OR 6'h36
`define LCISG_CODE_MAX 6'h36
`define LCISG_POOL_W 55

`endif

// [hdl/lcisg_pkg.sv]
package lcisg_pkg;
    // register port types
    typedef logic [4:0] lcisg_addr_t;
    typedef logic [7:0] lcisg_data_t;
    // one multiplexer selection code
    typedef logic [5:0] lcisg_code_t;
    // one gate enable byte, true form on even bits
    typedef logic [7:0] lcisg_gls_t;
endpackage : lcisg_pkg

// [hdl/lcisg_gate.sv]
`timescale 1ns/10ps
`include "lcisg_regs.svh"

module lcisg_gate (
    input logic [3:0] i_mux_out,
    input lcisg_pkg::lcisg_gls_t i_enable,
    input logic i_polarity,
    output logic o_gate_out
);
    import lcisg_pkg::*;

    // and of enabled terms, then polarity
    always_comb begin
        logic and_v;
        and_v = 1'b1; // no enabled term leaves a one
        for (int n = 0; n < 4; n++) begin
            if (i_enable[2 * n + `LCISG_GLS_TRUE_OFS]) begin
                and_v = and_v & i_mux_out[n];
            end
            if (i_enable[2 * n + `LCISG_GLS_INV_OFS]) begin
                and_v = and_v & ~i_mux_out[n];
            end
        end
        o_gate_out = i_polarity ? and_v : ~and_v;
    end
endmodule : lcisg_gate

// [hdl/lcisg_top.sv]
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "lcisg_regs.svh"

module lcisg_top (
    input wire logic i_clk,
    input wire logic i_rst_b,
    // register port
    input lcisg_pkg::lcisg_addr_t i_addr,
    input lcisg_pkg::lcisg_data_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output lcisg_pkg::lcisg_data_t o_rdata,
    // general pin inputs, after pin routing
    input wire logic [3:0] i_general_pin_input,
    // outputs of logic cells one to four
    input wire logic [3:0] i_cell_output,
    // synchronized comparator outputs one to eight
    input wire logic [7:0] i_synced_comparator_out,
    // output generator a and b lines, units one to four
    input wire logic [3:0] i_comp_output_gen_a,
    input wire logic [3:0] i_comp_output_gen_b,
    // capture compare units 1, 2, 7, 8
    input wire logic [3:0] i_capture_compare_out,
    // pwm 3, 4, 9, 10, 5, 6, 11, 12
    input wire logic [7:0] i_pwm_output,
    // serial port lines
    input wire logic i_serial_clock,
    input wire logic i_serial_data_out,
    input wire logic i_zero_cross_output,
    input wire logic i_uart_transmit,
    input wire logic i_uart_receive,
    // timer 0, 1, 3, 5 overflow
    input wire logic [3:0] i_timer_overflow,
    // timer 2, 4, 6, 8 postscaled
    input wire logic [3:0] i_timer_postscaled,
    input wire logic i_pin_change_flag,
    // clock sources
    input wire logic i_converter_rc_clock,
    input wire logic i_slow_internal_osc,
    input wire logic i_fast_internal_osc,
    input wire logic i_system_clock_source,
    // modulators one to three
    input wire logic [2:0] i_modulator_output,
    // to the logic function stage
    output logic [3:0] o_gate_out,
    output logic [3:0] o_mux_out
);
    import lcisg_pkg::*;

    // configuration registers
    lcisg_code_t sel_r [4];
    lcisg_gls_t gls_r [4];
    logic [3:0] pol_r;

    // read side
    lcisg_data_t rdata_r;
    lcisg_data_t rdata_nxt;

    // source pool and selection path
    logic [`LCISG_POOL_W-1:0] pool;
    logic [63:0] pool_full;
    logic [3:0] mux_out;
    logic [3:0] gate_out;
    logic [3:0] bad_sel;

    // pin inputs at codes 0 to 3
    assign pool[`LCISG_CODE_PIN0 +: 4] = i_general_pin_input;

    // cell outputs fed back at codes 4 to 7
    assign pool[`LCISG_CODE_CELL1 +: 4] = i_cell_output;

    // synchronized comparators
    assign pool[`LCISG_CODE_CMP1 +: 8] = i_synced_comparator_out;

    // output generator lines interleave a then b per unit
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_cog
            assign pool[`LCISG_CODE_COMP_OUTPUT_GEN1_A + 2 * k] = i_comp_output_gen_a[k];
            assign pool[`LCISG_CODE_COMP_OUTPUT_GEN1_A + 2 * k + 1] = i_comp_output_gen_b[k];
        end
    endgenerate

    // capture compare and pwm groups
    assign pool[`LCISG_CODE_CCP +: 4] = i_capture_compare_out;
    assign pool[`LCISG_CODE_PWM +: 8] = i_pwm_output;

    // serial, zero cross and uart lines
    assign pool[`LCISG_CODE_SER_CLK] = i_serial_clock;
    assign pool[`LCISG_CODE_SER_DAT] = i_serial_data_out;
    assign pool[`LCISG_CODE_ZCD] = i_zero_cross_output;
    assign pool[`LCISG_CODE_UART_TX] = i_uart_transmit;
    assign pool[`LCISG_CODE_UART_RX] = i_uart_receive;

    // timer events and change flag
    assign pool[`LCISG_CODE_TMR_OVF +: 4] = i_timer_overflow;
    assign pool[`LCISG_CODE_TMR_PST +: 4] = i_timer_postscaled;
    assign pool[`LCISG_CODE_IOC] = i_pin_change_flag;

    // clocks and modulator or at the top codes
    assign pool[`LCISG_CODE_RC_CLK] = i_converter_rc_clock;
    assign pool[`LCISG_CODE_SLOW_OSC] = i_slow_internal_osc;
    assign pool[`LCISG_CODE_FAST_OSC] = i_fast_internal_osc;
    assign pool[`LCISG_CODE_SYS_CLK] = i_system_clock_source;
    assign pool[`LCISG_CODE_MOD_OR] = |i_modulator_output;

    // unused codes read the pool as zero
    assign pool_full = {{(64 - `LCISG_POOL_W){1'b0}}, pool};

    // four independent multiplexers and their gates
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_path
            // pure selection, no register in the path
            assign mux_out[g] = pool_full[sel_r[g]];
            assign bad_sel[g] = (sel_r[g] > `LCISG_CODE_MAX);

            // each gate sees all four mux outputs
            lcisg_gate u_gate (
                .i_mux_out(mux_out),
                .i_enable(gls_r[g]),
                .i_polarity(pol_r[g]),
                .o_gate_out(gate_out[g])
            );
        end
    endgenerate

    // gate results go straight to the function stage
    assign o_gate_out = gate_out;
    assign o_mux_out = mux_out;

    // selection registers, written at any time
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < 4; i++) begin
                sel_r[i] <= `LCISG_RST_SEL;
            end
        end else if (i_wr) begin
            for (int i = 0; i < 4; i++) begin
                if (i_addr == (`LCISG_ADDR_SEL0 + 5'(i))) begin
                    sel_r[i] <= i_wdata[5:0];
                end
            end
        end
    end

    // gate select registers, one per gate
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < 4; i++) begin
                gls_r[i] <= `LCISG_RST_GLS;
            end
        end else if (i_wr) begin
            for (int i = 0; i < 4; i++) begin
                if (i_addr == (`LCISG_ADDR_GLS0 + 5'(i))) begin
                    gls_r[i] <= i_wdata;
                end
            end
        end
    end

    // gate output polarity bits
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pol_r <= `LCISG_RST_POL;
        end else if (i_wr && (i_addr == `LCISG_ADDR_POL)) begin
            pol_r <= i_wdata[3:0];
        end
    end

    // read decode, zero outside a read or on a hole
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_rd) begin
            for (int i = 0; i < 4; i++) begin
                if (i_addr == (`LCISG_ADDR_SEL0 + 5'(i))) begin
                    rdata_nxt = {2'h0, sel_r[i]};
                end
                if (i_addr == (`LCISG_ADDR_GLS0 + 5'(i))) begin
                    rdata_nxt = gls_r[i];
                end
            end
            for (int i = 0; i < `LCISG_POOL_REGS; i++) begin
                if (i_addr == (`LCISG_ADDR_POOL0 + 5'(i))) begin
                    rdata_nxt = pool_full[8 * i +: 8];
                end
            end
            if (i_addr == `LCISG_ADDR_POL) begin
                rdata_nxt = {4'h0, pol_r};
            end
            if (i_addr == `LCISG_ADDR_MUXST) begin
                rdata_nxt = {4'h0, mux_out};
            end
            if (i_addr == `LCISG_ADDR_GATEST) begin
                rdata_nxt = {4'h0, gate_out};
            end
            if (i_addr == `LCISG_ADDR_BADSEL) begin
                rdata_nxt = {4'h0, bad_sel};
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;

endmodule : lcisg_top

// [tb/lcisg_monitor.sv]
`timescale 1ns/10ps
`include "lcisg_regs.svh"
module lcisg_monitor (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input lcisg_pkg::lcisg_addr_t i_addr,
    input lcisg_pkg::lcisg_data_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input lcisg_pkg::lcisg_data_t o_rdata,
    input wire logic [3:0] i_general_pin_input,
    input wire logic [3:0] o_gate_out,
    input wire logic [3:0] o_mux_out
);
    import lcisg_pkg::*;
    lcisg_gls_t gls_r [4];
    lcisg_code_t sel0_r;
    logic [3:0] pol_r;
    logic [3:0] ref_gate;
    // shadow copy of configuration writes
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gls_r <= '{default: 8'h00};
            sel0_r <= 6'h00;
            pol_r <= 4'h0;
        end else if (i_wr) begin
            if (i_addr == `LCISG_ADDR_SEL0) sel0_r <= i_wdata[5:0];
            if (i_addr[4:2] == 3'h1) gls_r[i_addr[1:0]] <= i_wdata;
            if (i_addr == `LCISG_ADDR_POL) pol_r <= i_wdata[3:0];
        end
    end
    // reference gate: and of enabled terms, then polarity
    function automatic logic gate_ref(lcisg_gls_t e, logic [3:0] m, logic p);
        logic t;
        t = 1'b1;
        for (int n = 0; n < 4; n++) t &= (!e[2*n] | m[n]) & (!e[2*n+1] | !m[n]);
        return p ? t : !t;
    endfunction : gate_ref
    always_comb for (int g = 0; g < 4; g++) ref_gate[g] = gate_ref(gls_r[g], o_mux_out, pol_r[g]);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    gate_func_a: assert property (o_gate_out == ref_gate)
        else $error("gate output differs from reference");
    gate_and_a: assert property (gls_r[0] == 8'h55 && pol_r[0] |-> o_gate_out[0] == &o_mux_out)
        else $error("gate one not an and");
    gate_const_a: assert property (gls_r[0] == 8'h00 |-> o_gate_out[0] == pol_r[0])
        else $error("empty gate not at polarity level");
    gate_cmpl_a: assert property (gls_r[3][1:0] == 2'h3 |-> o_gate_out[3] != pol_r[3])
        else $error("complement pair not forcing zero");
    pin_route_a: assert property (sel0_r < 6'h04 |-> o_mux_out[0] == i_general_pin_input[sel0_r[1:0]])
        else $error("pin input not routed");
    live_write_a: assert property (i_wr && i_addr == `LCISG_ADDR_POL && gls_r[0] == 8'h00
        |=> o_gate_out[0] == $past(i_wdata[0]))
        else $error("polarity write not live");
    gls_read_a: assert property (i_rd && i_addr == `LCISG_ADDR_GLS0 |=> o_rdata == $past(gls_r[0]))
        else $error("gate enable readback wrong");
    mux_read_a: assert property (i_rd && i_addr == `LCISG_ADDR_MUXST
        |=> o_rdata == {4'h0, $past(o_mux_out)})
        else $error("mux status readback wrong");
endmodule : lcisg_monitor
bind lcisg_top lcisg_monitor u_mon (.*);

// [tb/lcisg_stage_model.sv]
`timescale 1ns/10ps
module lcisg_stage_model (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [3:0] i_gate_out,
    output logic o_cell_out
);
    // four-input and stage, clocked so a self loop cannot ring
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cell_out <= 1'b0;
        end else begin
            o_cell_out <= &i_gate_out;
        end
    end
endmodule : lcisg_stage_model

// [tb/lcisg_tb.sv]
`timescale 1ns/10ps
`include "lcisg_regs.svh"
module lcisg_tb;
    import lcisg_pkg::*;
    logic i_clk, i_rst_b, i_wr, i_rd, cell1;
    lcisg_addr_t i_addr;
    lcisg_data_t i_wdata, o_rdata, rv;
    logic [56:0] src;
    logic [3:0] o_gate_out, o_mux_out;
    int bad_count, num_checks, cyc;
    lcisg_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_general_pin_input(src[3:0]),
        .i_cell_output({src[7:5], cell1}), .i_synced_comparator_out(src[15:8]),
        .i_comp_output_gen_a({src[22], src[20], src[18], src[16]}),
        .i_comp_output_gen_b({src[23], src[21], src[19], src[17]}),
        .i_capture_compare_out(src[27:24]), .i_pwm_output(src[35:28]),
        .i_serial_clock(src[36]), .i_serial_data_out(src[37]), .i_zero_cross_output(src[38]),
        .i_uart_transmit(src[39]), .i_uart_receive(src[40]), .i_timer_overflow(src[44:41]),
        .i_timer_postscaled(src[48:45]), .i_pin_change_flag(src[49]),
        .i_converter_rc_clock(src[50]), .i_slow_internal_osc(src[51]),
        .i_fast_internal_osc(src[52]), .i_system_clock_source(src[53]),
        .i_modulator_output(src[56:54]), .o_gate_out(o_gate_out), .o_mux_out(o_mux_out));
    lcisg_stage_model u_stage (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_gate_out(o_gate_out),
        .o_cell_out(cell1));
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(lcisg_addr_t a, lcisg_data_t d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(lcisg_addr_t a, output lcisg_data_t d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask : rd
    // reset state, readback, constant gates, read-only place
    task automatic t_reset();
        chk({4'h0, o_gate_out}, 8'h00);
        for (int a = 0; a < 9; a++) begin
            rd(5'(a), rv);
            chk(rv, 8'h00);
        end
        wr(`LCISG_ADDR_MUXST, 8'hFF);
        rd(`LCISG_ADDR_MUXST, rv);
        chk(rv, 8'h00);
        rd(5'h1F, rv);
        chk(rv, 8'h00);
        wr(`LCISG_ADDR_POL, 8'h0F);
        chk({4'h0, o_gate_out}, 8'h0F);
    endtask : t_reset
    // every code but 4 (cell one) on its mux, one source high at a time, over range all high
    task automatic t_route();
        for (int c = 0; c < 64; c++) begin
            if (c == 4) continue;
            wr(5'(c % 4), 8'(c));
            @(posedge i_clk);
            src <= (c > 54) ? {57{1'b1}} : 57'h1 << c;
            #1;
            chk({7'h0, o_mux_out[c % 4]}, {7'h0, c < 55});
            rd(`LCISG_ADDR_BADSEL, rv);
            chk({7'h0, rv[c % 4]}, {7'h0, c > 54});
            if (c < 56) begin
                rd(`LCISG_ADDR_POOL0 + 5'(c / 8), rv);
                chk({7'h0, rv[c % 8]}, {7'h0, c < 55});
            end
            @(posedge i_clk);
            src <= 57'h0;
            #1;
            chk({7'h0, o_mux_out[c % 4]}, 8'h00);
        end
    endtask : t_route
    // four gate kinds side by side, all pin patterns, both polarities
    task automatic t_gates();
        logic [3:0] t;
        for (int m = 0; m < 4; m++) wr(5'(m), 8'(m));
        wr(5'h04, 8'h55);
        wr(5'h05, 8'hAA);
        wr(5'h06, 8'h24);
        wr(5'h07, 8'h03);
        for (int p = 0; p < 32; p++) begin
            wr(`LCISG_ADDR_POL, {4'h0, {4{p[4]}}});
            @(posedge i_clk);
            src <= 57'(p[3:0]);
            #1;
            t = {1'b0, p[1] & !p[2], ~|p[3:0], &p[3:0]};
            chk({4'h0, o_gate_out}, {4'h0, p[4] ? t : ~t});
            rd(`LCISG_ADDR_MUXST, rv);
            chk(rv, {4'h0, p[3:0]});
            rd(`LCISG_ADDR_GATEST, rv);
            chk(rv, {4'h0, p[4] ? t : ~t});
        end
        rd(5'h07, rv);
        chk(rv, 8'h03);
    endtask : t_gates
    // cell one fed back through the downstream stage
    task automatic t_feed();
        wr(5'h00, 8'h04);
        for (int g = 4; g < 8; g++) wr(5'(g), 8'h00);
        for (int k = 1; k >= 0; k--) begin
            wr(`LCISG_ADDR_POL, {4'h0, 3'h7, k[0]});
            @(posedge i_clk);
            #1;
            chk({7'h0, o_mux_out[0]}, {7'h0, k[0]});
        end
    endtask : t_feed
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // hang guard
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        {i_rst_b, i_wr, i_rd, i_addr, i_wdata, src} = '0;
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_reset();
        $display("reset test done");
        t_route();
        $display("route test done");
        t_gates();
        $display("gate test done");
        t_feed();
        $display("feedback test done");
        stop_test();
    end
endmodule : lcisg_tb
